// ### urai_defines.svh
// constants for the udp remote register interpreter
//
// Behaviour
// - command bit 15 set means write
// - bit 14 adds address, loaded into pointer
// - each space keeps its own pointer
// - bit 13 selects info area, not space
// - bits 12..10 select one of eight spaces
// - bits 9..8 give element width 8..64
// - bit 7 advances pointer by element bytes
// - bits 6..0 count elements, zero is error
// - reads carry address only, writes carry data
// - all addresses and pointers are byte addresses
// - all fields travel least significant byte first
// - info area is read only, 16-bit only
// - info offset 0 returns cookie with space
// - info offsets 2,4,6,8..14 give descriptors, pointer, label
// - size descriptor bit 15 means writable
// - size descriptor bits 14..8 give space type
// - size descriptor bits 3..0 mask allowed widths
// - extent descriptor packs erase, page, range exponents
// - requests arrive on udp port 27181
// - replies go to requester's source port
`ifndef URAI_DEFINES_SVH
`define URAI_DEFINES_SVH

// command fields
`define URAI_CMD_WRITE_BIT 15
`define URAI_CMD_ADDR_BIT 14
`define URAI_CMD_INFO_BIT 13
`define URAI_CMD_SPACE_MSB 12
`define URAI_CMD_SPACE_LSB 10
`define URAI_CMD_SIZE_MSB 9
`define URAI_CMD_SIZE_LSB 8
`define URAI_CMD_INC_BIT 7
`define URAI_CMD_COUNT_MSB 6
`define URAI_CMD_COUNT_LSB 0

// info area offsets (word index = byte offset / 2)
`define URAI_INFO_COOKIE 3'h0
`define URAI_INFO_SIZE 3'h1
`define URAI_INFO_RANGE 3'h2
`define URAI_INFO_POINTER 3'h3
`define URAI_INFO_LABEL0 3'h4
`define URAI_INFO_LABEL1 3'h5
`define URAI_INFO_LABEL2 3'h6
`define URAI_INFO_LABEL3 3'h7
`define URAI_INFO_LAST_BYTE 16'h000f
`define URAI_COOKIE_BASE 16'h5a00

// size descriptor fields and space types
`define URAI_SD_WRITABLE_BIT 15
`define URAI_SD_TYPE_MSB 14
`define URAI_SD_TYPE_LSB 8
`define URAI_SD_MASK_MSB 3
`define URAI_SD_MASK_LSB 0
`define URAI_TYPE_REGISTER 7'h01
`define URAI_TYPE_MEMORY 7'h02
`define URAI_TYPE_EEPROM 7'h0e
`define URAI_TYPE_FLASH 7'h0f

// extent descriptor fields
`define URAI_ED_ERASE_MSB 15
`define URAI_ED_ERASE_LSB 11
`define URAI_ED_PAGE_MSB 10
`define URAI_ED_PAGE_LSB 6
`define URAI_ED_RANGE_MSB 5
`define URAI_ED_RANGE_LSB 0

// udp port 27181
`define URAI_UDP_PORT 16'h6a2d

// reset values and default fifo depth
`define URAI_PTR_RESET 16'h0000
`define URAI_FIFO_DEPTH 4

`endif

// ### urai_pkg.sv
// types shared by the udp remote register interpreter
package urai_pkg;

  // gray coded along idle -> cmd -> address -> setup -> data -> access -> reply
  typedef enum logic [3:0] {
    URAI_IDLE = 4'h0,
    URAI_CMD_HI = 4'h1,
    URAI_ADR_LO = 4'h3,
    URAI_ADR_HI = 4'h2,
    URAI_SETUP = 4'h6,
    URAI_WDATA = 4'h7,
    URAI_ACCESS = 4'h5,
    URAI_RSEND = 4'h4,
    URAI_FIN = 4'hc,
    URAI_DRAIN = 4'hd
  } urai_state_type;

  // element width codes
  typedef enum logic [1:0] {
    URAI_W8 = 2'h0,
    URAI_W16 = 2'h1,
    URAI_W32 = 2'h2,
    URAI_W64 = 2'h3
  } urai_width_type;

endpackage

// ### urai_interp.sv
// udp remote register interpreter with its receive fifo
`timescale 1ns/1ps
`include "urai_defines.svh"

// small valid/ready fifo, registered flags
module urai_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  logic [AW:0] cnt_d;

  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign o_out_data = mem_q[rd_q];

  // storage, no reset needed on data
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  // pointers and flags; full flag held in a flop so ready stalls the source cleanly
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      o_in_ready <= 1'b0;
      o_out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      o_in_ready <= (cnt_d != (AW+1)'(DEPTH));
      o_out_valid <= (cnt_d != '0);
    end
  end
endmodule

module urai_interp
  import urai_pkg::*;
#(
  parameter int FIFO_DEPTH = `URAI_FIFO_DEPTH,
  parameter logic [8*16-1:0] P_SIZE_DESC = {8{16'h8206}},
  parameter logic [8*16-1:0] P_RANGE_DESC = {8{16'h0010}},
  parameter logic [8*64-1:0] P_LABEL = '0
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // udp payload in, one byte per beat
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_last,
  input wire logic [15:0] i_rx_dst_port,
  input wire logic [15:0] i_rx_src_port,
  output logic o_rx_ready,
  // reply payload out
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  output logic [15:0] o_tx_port,
  input wire logic i_tx_ready,
  output logic o_tx_end,
  // access to the memory spaces
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [2:0] o_mem_space,
  output logic [1:0] o_mem_width,
  output logic [15:0] o_mem_addr,
  output logic [63:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic [63:0] i_mem_rdata,
  // sticky error, cleared by software pulse
  output logic o_cmd_error,
  input wire logic i_err_clear
);
  localparam int FW = 8 + 1 + 32;

  urai_state_type state_q;
  logic [15:0] cmd_q;
  logic [15:0] ptr_q [8];
  logic [6:0] cnt_q;
  logic [2:0] bidx_q;
  logic [63:0] data_q;
  logic [15:0] src_q;
  logic in_pkt_q;
  logic pkt_end_q;
  logic skip_q;
  logic f_valid;
  logic [FW-1:0] f_data;
  logic want_byte;
  logic take;
  logic [7:0] f_byte;
  logic f_last;
  logic [15:0] f_dst;
  logic [15:0] f_src;
  logic elem_done;
  logic err_set;
  logic is_write;
  logic is_info;
  logic [2:0] space;
  logic [1:0] width;
  logic [2:0] last_idx;

  // received bytes travel with their packet ports so packets never mix
  urai_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(i_rx_valid),
    .i_in_data({i_rx_dst_port, i_rx_src_port, i_rx_last, i_rx_data}),
    .o_in_ready(o_rx_ready),
    .o_out_valid(f_valid),
    .o_out_data(f_data),
    .i_out_ready(take)
  );

  assign {f_dst, f_src, f_last, f_byte} = f_data;

  // decoded command fields
  assign is_write = cmd_q[`URAI_CMD_WRITE_BIT];
  assign is_info = cmd_q[`URAI_CMD_INFO_BIT];
  assign space = cmd_q[`URAI_CMD_SPACE_MSB:`URAI_CMD_SPACE_LSB];
  assign width = cmd_q[`URAI_CMD_SIZE_MSB:`URAI_CMD_SIZE_LSB];
  assign last_idx = elem_last(width);

  // last byte index of an element, used by write collect and reply
  function automatic logic [2:0] elem_last(input logic [1:0] w);
    case (w)
      URAI_W8: elem_last = 3'h0;
      URAI_W16: elem_last = 3'h1;
      URAI_W32: elem_last = 3'h3;
      default: elem_last = 3'h7;
    endcase
  endfunction

  // info area word for a space at a byte offset
  function automatic logic [15:0] info_word(input logic [2:0] sp, input logic [15:0] off, input logic [15:0] ptr);
    logic [63:0] lbl;
    lbl = P_LABEL[sp*64 +: 64];
    if (off > `URAI_INFO_LAST_BYTE) begin
      info_word = 16'h0000;
    end else begin
      case (off[3:1])
        `URAI_INFO_COOKIE: info_word = `URAI_COOKIE_BASE | {13'h0000, sp};
        `URAI_INFO_SIZE: info_word = P_SIZE_DESC[sp*16 +: 16];
        `URAI_INFO_RANGE: info_word = P_RANGE_DESC[sp*16 +: 16];
        `URAI_INFO_POINTER: info_word = ptr;
        `URAI_INFO_LABEL0: info_word = lbl[15:0];
        `URAI_INFO_LABEL1: info_word = lbl[31:16];
        `URAI_INFO_LABEL2: info_word = lbl[47:32];
        default: info_word = lbl[63:48];
      endcase
    end
  endfunction

  // states that consume fifo bytes; stalls when starved
  always_comb begin
    case (state_q)
      URAI_IDLE, URAI_CMD_HI, URAI_ADR_LO, URAI_ADR_HI, URAI_WDATA: want_byte = !pkt_end_q;
      URAI_DRAIN: want_byte = 1'b1;
      default: want_byte = 1'b0;
    endcase
  end
  assign take = want_byte && f_valid;

  // one element finished: write acknowledged, last reply byte gone, or ignored data eaten
  always_comb begin
    elem_done = 1'b0;
    case (state_q)
      URAI_ACCESS: elem_done = is_write && i_mem_ack && o_mem_req;
      URAI_RSEND: elem_done = o_tx_valid && i_tx_ready && (bidx_q == last_idx);
      URAI_WDATA: elem_done = take && skip_q && (bidx_q == last_idx);
      default: elem_done = 1'b0;
    endcase
  end

  // error sources: zero count, illegal info access, truncated command
  always_comb begin
    err_set = 1'b0;
    if (state_q == URAI_SETUP) begin
      if (cmd_q[`URAI_CMD_COUNT_MSB:`URAI_CMD_COUNT_LSB] == 7'h00) begin
        err_set = 1'b1;
      end else if (is_info && (is_write || width != URAI_W16)) begin
        err_set = 1'b1;
      end
    end
    if (state_q != URAI_IDLE && state_q != URAI_DRAIN && want_byte == 1'b0 && pkt_end_q &&
        (state_q == URAI_CMD_HI || state_q == URAI_ADR_LO || state_q == URAI_ADR_HI ||
         state_q == URAI_WDATA)) begin
      err_set = 1'b1;
    end
  end

  // main sequencer
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= URAI_IDLE;
      cmd_q <= 16'h0000;
      src_q <= 16'h0000;
      in_pkt_q <= 1'b0;
      pkt_end_q <= 1'b0;
      skip_q <= 1'b0;
      cnt_q <= 7'h00;
      bidx_q <= 3'h0;
    end else begin
      if (take) begin
        pkt_end_q <= f_last;
      end
      case (state_q)
        URAI_IDLE: begin
          if (pkt_end_q) begin
            state_q <= URAI_FIN;
          end else if (take) begin
            cmd_q[7:0] <= f_byte;
            in_pkt_q <= 1'b1;
            if (!in_pkt_q) begin
              src_q <= f_src;
            end
            if (!in_pkt_q && f_dst != `URAI_UDP_PORT) begin
              state_q <= f_last ? URAI_IDLE : URAI_DRAIN;
              in_pkt_q <= 1'b0;
              pkt_end_q <= 1'b0;
            end else begin
              state_q <= URAI_CMD_HI;
            end
          end
        end
        URAI_CMD_HI: begin
          if (pkt_end_q) begin
            state_q <= URAI_FIN;
          end else if (take) begin
            cmd_q[15:8] <= f_byte;
            state_q <= f_byte[`URAI_CMD_ADDR_BIT-8] ? URAI_ADR_LO : URAI_SETUP;
          end
        end
        URAI_ADR_LO: begin
          if (pkt_end_q) begin
            state_q <= URAI_FIN;
          end else if (take) begin
            state_q <= URAI_ADR_HI;
          end
        end
        URAI_ADR_HI: begin
          if (pkt_end_q) begin
            state_q <= URAI_FIN;
          end else if (take) begin
            state_q <= URAI_SETUP;
          end
        end
        URAI_SETUP: begin
          cnt_q <= cmd_q[`URAI_CMD_COUNT_MSB:`URAI_CMD_COUNT_LSB];
          bidx_q <= 3'h0;
          skip_q <= 1'b0;
          if (cmd_q[`URAI_CMD_COUNT_MSB:`URAI_CMD_COUNT_LSB] == 7'h00) begin
            state_q <= URAI_IDLE;
          end else if (is_info && (is_write || width != URAI_W16)) begin
            // bad info access: eat any write data, touch nothing
            skip_q <= is_write;
            state_q <= is_write ? URAI_WDATA : URAI_IDLE;
          end else begin
            state_q <= is_write ? URAI_WDATA : URAI_ACCESS;
          end
        end
        URAI_WDATA: begin
          if (pkt_end_q) begin
            state_q <= URAI_FIN;
          end else if (take) begin
            bidx_q <= (bidx_q == last_idx) ? 3'h0 : bidx_q + 3'h1;
            if (bidx_q == last_idx && !skip_q) begin
              state_q <= URAI_ACCESS;
            end
          end
        end
        URAI_ACCESS: begin
          if (is_info || i_mem_ack) begin
            if (!is_write) begin
              state_q <= URAI_RSEND;
              bidx_q <= 3'h0;
            end
          end
        end
        URAI_RSEND: begin
          if (o_tx_valid && i_tx_ready && bidx_q != last_idx) begin
            bidx_q <= bidx_q + 3'h1;
          end
        end
        URAI_FIN: begin
          in_pkt_q <= 1'b0;
          pkt_end_q <= 1'b0;
          state_q <= URAI_IDLE;
        end
        URAI_DRAIN: begin
          if (take && f_last) begin
            pkt_end_q <= 1'b0;
            state_q <= URAI_IDLE;
          end
        end
        default: state_q <= URAI_IDLE;
      endcase
      // element loop: repeat until count is used up
      if (elem_done) begin
        bidx_q <= 3'h0;
        cnt_q <= cnt_q - 7'h01;
        if (cnt_q == 7'h01) begin
          state_q <= URAI_IDLE;
        end else begin
          state_q <= is_write ? URAI_WDATA : URAI_ACCESS;
        end
      end
    end
  end

  // per-space pointers: load from address, advance after each element
  genvar gs;
  generate
    for (gs = 0; gs < 8; gs++) begin : g_ptr
      always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          ptr_q[gs] <= `URAI_PTR_RESET;
        end else if (space == 3'(gs)) begin
          if (take && state_q == URAI_ADR_LO) begin
            ptr_q[gs][7:0] <= f_byte;
          end else if (take && state_q == URAI_ADR_HI) begin
            ptr_q[gs][15:8] <= f_byte;
          end else if (elem_done && !skip_q && cmd_q[`URAI_CMD_INC_BIT]) begin
            // byte addressing: step is the element size in bytes
            ptr_q[gs] <= ptr_q[gs] + {13'h0000, last_idx} + 16'h0001;
          end
        end
      end
    end
  endgenerate

  // element data: write bytes collected lsb first, read data captured whole
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      data_q <= 64'h0000000000000000;
    end else if (take && state_q == URAI_WDATA) begin
      data_q[bidx_q*8 +: 8] <= f_byte;
    end else if (state_q == URAI_ACCESS && !is_write && is_info) begin
      data_q <= {48'h000000000000, info_word(space, ptr_q[space], ptr_q[space])};
    end else if (state_q == URAI_ACCESS && !is_write && i_mem_ack && o_mem_req) begin
      data_q <= i_mem_rdata;
    end
  end

  // memory request, held until acknowledged
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mem_req <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_space <= 3'h0;
      o_mem_width <= 2'h0;
      o_mem_addr <= 16'h0000;
      o_mem_wdata <= 64'h0000000000000000;
    end else if (o_mem_req) begin
      if (i_mem_ack) begin
        o_mem_req <= 1'b0;
      end
    end else if (state_q == URAI_ACCESS && !is_info) begin
      o_mem_req <= 1'b1;
      o_mem_we <= is_write;
      o_mem_space <= space;
      o_mem_width <= width;
      o_mem_addr <= ptr_q[space];
      o_mem_wdata <= data_q;
    end
  end

  // reply bytes in command order, lsb first, to the requester's port
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_valid <= 1'b0;
      o_tx_data <= 8'h00;
      o_tx_port <= 16'h0000;
      o_tx_end <= 1'b0;
    end else begin
      o_tx_end <= (state_q == URAI_FIN);
      o_tx_port <= src_q;
      if (state_q == URAI_RSEND) begin
        if (!o_tx_valid) begin
          o_tx_valid <= 1'b1;
          o_tx_data <= data_q[7:0];
        end else if (i_tx_ready) begin
          if (bidx_q == last_idx) begin
            o_tx_valid <= 1'b0;
          end else begin
            o_tx_data <= data_q[(bidx_q+3'h1)*8 +: 8];
          end
        end
      end
    end
  end

  // sticky error; a new error wins over a clear in the same cycle
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cmd_error <= 1'b0;
    end else if (err_set) begin
      o_cmd_error <= 1'b1;
    end else if (i_err_clear) begin
      o_cmd_error <= 1'b0;
    end
  end
endmodule

// ### urai_interp_monitor.sv
// assertion checker for the udp register interpreter ports
`timescale 1ns/1ps
module urai_interp_monitor (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic o_rx_ready,
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_data,
  input wire logic [15:0] o_tx_port,
  input wire logic i_tx_ready,
  input wire logic o_tx_end,
  input wire logic o_mem_req,
  input wire logic o_mem_we,
  input wire logic [2:0] o_mem_space,
  input wire logic [1:0] o_mem_width,
  input wire logic [15:0] o_mem_addr,
  input wire logic [63:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic o_cmd_error,
  input wire logic i_err_clear
);
  // one clock domain, so clock and reset are given once
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_req_held_steady:
    assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_space)
      && $stable(o_mem_width) && $stable(o_mem_we) && $stable(o_mem_wdata))
    else $error("memory request changed before ack");
  a_req_drop_ack:
    assert property (o_mem_req && i_mem_ack |=> !o_mem_req)
    else $error("memory request stayed after ack");
  a_req_spacing_two:
    assert property ($fell(o_mem_req) |=> !o_mem_req)
    else $error("memory requests closer than two cycles");
  a_tx_held_ready:
    assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data) && $stable(o_tx_port))
    else $error("reply byte dropped before ready");
  a_end_one_pulse:
    assert property (o_tx_end |=> !o_tx_end)
    else $error("reply end longer than one cycle");
  a_err_sticky_hold:
    assert property (o_cmd_error && !i_err_clear |=> o_cmd_error)
    else $error("error flag lost without clear");
  a_err_clear_cause:
    assert property ($fell(o_cmd_error) |-> $past(i_err_clear))
    else $error("error flag fell without clear");
  a_ready_after_reset:
    assert property (!$past(i_rst_n) |=> o_rx_ready)
    else $error("receive ready late after reset");
endmodule

bind urai_interp urai_interp_monitor u_urai_interp_monitor (.*);

// ### urai_host_model.sv
// host model: sends datagram bytes and collects reply bytes
`timescale 1ns/1ps
module urai_host_model (
  input wire logic i_core_clk,
  input wire logic i_rx_ready,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_last,
  output logic [15:0] o_dst_port,
  output logic [15:0] o_src_port,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready
);
  logic [7:0] q[$];
  logic [7:0] rq[$];
  logic stall = 1'b0;
  logic [1:0] ph = 2'h0;
  int refused = 0;
  int hung = 0;

  // idle lines at time zero
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
    o_rx_last = 1'b0;
    o_dst_port = 16'h0000;
    o_src_port = 16'h0000;
  end

  // a slow sink takes one byte in four
  assign o_tx_ready = !stall || (ph == 2'h3);

  // reply capture and refusal count
  always @(posedge i_core_clk) begin
    ph <= ph + 2'h1;
    if (i_tx_valid && o_tx_ready)
      rq.push_back(i_tx_data);
    if (o_rx_valid && !i_rx_ready)
      refused++;
  end

  // whole datagram, bytes queued lsb first, each held until taken or 400 cycles pass
  task automatic send(input logic [15:0] dport, input logic [15:0] sport);
    int n;
    while (q.size() > 0) begin
      o_rx_valid <= 1'b1;
      o_rx_data <= q[0];
      o_rx_last <= (q.size() == 1);
      o_dst_port <= dport;
      o_src_port <= sport;
      n = 0;
      do begin
        @(posedge i_core_clk);
        n++;
      end while (!i_rx_ready && n < 400);
      if (!i_rx_ready)
        hung++;
      void'(q.pop_front());
    end
    // released line shows no stale byte
    o_rx_valid <= 1'b0;
    o_rx_data <= ~o_rx_data;
  endtask
endmodule

// ### urai_interp_tb.sv
// self-checking bench for the udp register interpreter
`timescale 1ns/1ps
module urai_interp_tb;
  typedef struct {
    logic [63:0] pkt;
    int len;
    logic we;
    logic [2:0] sp;
    logic [1:0] w;
    logic [15:0] a0;
    logic [15:0] step;
    int cnt;
    logic [63:0] wd;
  } urai_row_type;
  localparam logic [127:0] SIZE = {16'h0101, 16'h8102, 16'h0e02, 16'h8f04, 16'h0f06, 16'h8e02, 16'h8102, 16'h8104};
  localparam logic [127:0] RANGE = {16'h0010, 16'h0008, 16'h0007, 16'h8a56, 16'h0110, 16'h000f, 16'h0006, 16'h0010};
  localparam logic [511:0] LABEL = {8{64'h3736353433323130}};
  localparam logic [15:0] PORT = 16'h6a2d;
  logic i_core_clk, i_rst_n, i_rx_valid, i_rx_last, o_rx_ready, o_tx_valid, i_tx_ready, o_tx_end;
  logic [7:0] i_rx_data, o_tx_data;
  logic [15:0] i_rx_dst_port, i_rx_src_port, o_tx_port, o_mem_addr;
  logic o_mem_req, o_mem_we, o_cmd_error;
  logic [2:0] o_mem_space;
  logic [1:0] o_mem_width;
  logic [63:0] o_mem_wdata;
  logic i_mem_ack = 1'b0;
  logic [63:0] i_mem_rdata = 64'h0;
  logic i_err_clear = 1'b0;
  logic [85:0] log[$];
  int lat = 0;
  int wcnt = 0;
  int checks = 0;
  int num_errors = 0;
  urai_row_type rows[6] = '{
    '{64'h0000beef1234c101, 6, 1'b1, 3'h0, 2'h1, 16'h1234, 16'h0, 1, 64'hbeef},
    '{64'h0000000000104e82, 4, 1'b0, 3'h3, 2'h2, 16'h0010, 16'h4, 2, 64'h0},
    '{64'h0000000000000c01, 2, 1'b0, 3'h3, 2'h0, 16'h0018, 16'h0, 1, 64'h0},
    '{64'h0000000000000101, 2, 1'b0, 3'h0, 2'h1, 16'h1234, 16'h0, 1, 64'h0},
    '{64'h0000000000085f81, 4, 1'b0, 3'h7, 2'h3, 16'h0008, 16'h8, 1, 64'h0},
    '{64'h0000000000205503, 4, 1'b0, 3'h5, 2'h1, 16'h0020, 16'h0, 3, 64'h0}};
  logic [63:0] bad_pkt[4] = '{64'h01010000, 64'h2001, 64'hbeefa101, 64'h34c101};
  int bad_len[4] = '{4, 2, 4, 3};

  urai_interp #(.P_SIZE_DESC(SIZE), .P_RANGE_DESC(RANGE), .P_LABEL(LABEL)) u_urai_interp (.*);
  urai_host_model u_urai_host_model (.i_core_clk(i_core_clk), .i_rx_ready(o_rx_ready),
    .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data), .o_rx_last(i_rx_last), .o_dst_port(i_rx_dst_port),
    .o_src_port(i_rx_src_port), .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data), .o_tx_ready(i_tx_ready));

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  function automatic logic [63:0] mval(input logic [2:0] s, input logic [15:0] a);
    // address in the low bytes so the first reply byte of each element tells elements apart
    return {13'h0, s, a ^ 16'h5a5a, ~a, a};
  endfunction

  // memory spaces: answer after lat cycles, log every access
  always @(posedge i_core_clk) begin
    i_mem_ack <= 1'b0;
    i_mem_rdata <= ~i_mem_rdata;
    if (o_mem_req && !i_mem_ack) begin
      if (wcnt >= lat) begin
        i_mem_ack <= 1'b1;
        i_mem_rdata <= mval(o_mem_space, o_mem_addr);
        log.push_back({o_mem_we, o_mem_space, o_mem_width, o_mem_addr, o_mem_wdata});
        wcnt <= 0;
      end else
        wcnt <= wcnt + 1;
    end
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    num_errors += u_urai_host_model.hung;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic put(input logic [63:0] pkt, input int len);
    for (int i = 0; i < len; i++)
      u_urai_host_model.q.push_back(pkt[8*i+:8]);
  endtask

  // send queued datagram, then wait bounded for the reply end pulse
  task automatic run(input logic [15:0] dport, input logic [15:0] sport, input logic exp_end);
    int n;
    log.delete();
    u_urai_host_model.rq.delete();
    u_urai_host_model.send(dport, sport);
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_tx_end !== 1'b1 && n < 600);
    if (!exp_end)
      chk("stray reply end", 64'h0, {63'h0, o_tx_end});
    else if (o_tx_end !== 1'b1) begin
      num_errors++;
      $display("mismatch reply end expected 1 seen 0");
      end_of_test();
    end
  endtask

  initial begin
    logic [63:0] v;
    logic [15:0] iw[8];
    logic [15:0] a;
    i_rst_n = 1'b0;
    repeat (10) @(posedge i_core_clk);
    chk("reset outputs", 64'h0, {o_rx_ready, o_tx_valid, o_mem_req, o_cmd_error, o_tx_end});
    i_rst_n <= 1'b1;
    @(posedge i_core_clk);
    // ordinary accesses, one row per datagram
    foreach (rows[r]) begin
      put(rows[r].pkt, rows[r].len);
      run(PORT, 16'h4000 + 16'(r), 1'b1);
      chk("reply port", 16'h4000 + 16'(r), o_tx_port);
      chk("access count", rows[r].cnt, log.size());
      chk("reply length", rows[r].we ? 0 : rows[r].cnt << rows[r].w, u_urai_host_model.rq.size());
      for (int i = 0; i < rows[r].cnt; i++) begin
        a = rows[r].a0 + 16'(rows[r].step * i);
        v = mval(rows[r].sp, a);
        chk("access", {rows[r].we, rows[r].sp, rows[r].w, a}, log[i][85:64]);
        if (rows[r].we)
          chk("wdata", rows[r].wd, log[i][63:0] & ~(64'hffffffffffffffff << (8 << rows[r].w)));
        else
          for (int b = 0; b < (1 << rows[r].w); b++)
            chk("reply", v[8*b+:8], u_urai_host_model.rq[(i << rows[r].w) + b]);
      end
    end
    // info area of every space, eight words from offset zero
    for (int s = 0; s < 8; s++) begin
      put({48'h0, 8'h61 | 8'(s << 2), 8'h88}, 4);
      run(PORT, 16'h5000, 1'b1);
      chk("info access", 0, log.size());
      iw = '{16'h5a00 | 16'(s), SIZE[s*16+:16], RANGE[s*16+:16], 16'h0006, LABEL[s*64+:16],
        LABEL[s*64+16+:16], LABEL[s*64+32+:16], LABEL[s*64+48+:16]};
      for (int k = 0; k < 8; k++)
        chk("info", iw[k], {u_urai_host_model.rq[2*k+1], u_urai_host_model.rq[2*k]});
    end
    // info offset past the last label word reads as zero
    put(64'h00106901, 4);
    run(PORT, 16'h5000, 1'b1);
    chk("info beyond", 0, {u_urai_host_model.rq[1], u_urai_host_model.rq[0]});
    // zero count, narrow info read, info write, truncated datagram
    for (int j = 0; j < 4; j++) begin
      put(bad_pkt[j], bad_len[j]);
      run(PORT, 16'h6000, 1'b1);
      @(posedge i_core_clk);
      chk("error flag", 64'h1, o_cmd_error);
      chk("bad accesses", j == 0, log.size());
      chk("bad reply", j == 0 ? 2 : 0, u_urai_host_model.rq.size());
      i_err_clear <= 1'b1;
      @(posedge i_core_clk);
      i_err_clear <= 1'b0;
      @(posedge i_core_clk);
      chk("error cleared", 64'h0, o_cmd_error);
    end
    // datagram to another port is dropped whole
    put(64'h0101, 2);
    run(16'h6a2c, 16'h7000, 1'b0);
    chk("foreign accesses", 0, log.size() + u_urai_host_model.rq.size());
    // slow memory and slow sink: the fifo fills, refuses, then drains
    lat <= 20;
    u_urai_host_model.stall <= 1'b1;
    put(64'h443322110040c084, 8);
    put(64'h00404084, 4);
    run(PORT, 16'h7100, 1'b1);
    chk("fifo refused", 64'h1, u_urai_host_model.refused > 0);
    chk("fifo drained", 64'h1, o_rx_ready);
    for (int i = 0; i < 4; i++) begin
      v = mval(3'h0, 16'h0040 + 16'(i));
      chk("fill write", {1'b1, 3'h0, 2'h0, 16'h0040 + 16'(i), 8'h11 * 8'(i + 1)},
        {log[i][85:64], log[i][7:0]});
      chk("fill reply", v[7:0], u_urai_host_model.rq[i]);
    end
    // second reset clears the pointers
    lat <= 0;
    u_urai_host_model.stall <= 1'b0;
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    @(posedge i_core_clk);
    put(64'h0c01, 2);
    run(PORT, 16'h7200, 1'b1);
    chk("reset pointer", {1'b0, 3'h3, 2'h0, 16'h0000}, log[0][85:64]);
    end_of_test();
  end
endmodule
